// [logic/bcs_pkg.sv]
// Shared constants for the burst cache SRAM control block.
// Assumes a single synchronous clock domain and a synchronous active-low reset.
package bcs_pkg;
    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int BCS_ADDR_W = 16; // Word address width, 64K locations
    localparam int BCS_BURST_W = 2; // Burst counter width
    localparam int BCS_BYTE_W = 8; // Data bits per lane
    localparam int BCS_LANE_W = 9; // Data plus parity bit per lane
    localparam int BCS_LANES = 2; // Lane 1 is the high byte
    localparam int BCS_DATA_W = 16; // Data pins
    localparam int BCS_LANE_HI = 1; // Index of the high lane
    localparam int BCS_LANE_LO = 0; // Index of the low lane
    // ---------------------------------------------------------------
    // Burst order and reset values
    // ---------------------------------------------------------------
    localparam bit BCS_INTERLEAVED_DEF = 1'b1; // Default counter variant
    localparam logic [1:0] BCS_IDX_SECOND = 2'h1; // Offset of second beat
    localparam logic [1:0] BCS_IDX_FOURTH = 2'h3; // Offset of fourth beat
    localparam logic [1:0] BCS_CNT_RESET = 2'h0; // Counter after reset
    localparam logic [8:0] BCS_LANE_RESET = 9'h000; // Read lane after reset
    localparam int BCS_CLK_PERIOD_NS = 40; // System clock period
    // ---------------------------------------------------------------
    // Selection state
    // ---------------------------------------------------------------
    typedef enum logic {BCS_DESEL, BCS_ACTIVE} bcs_sel_e;
endpackage : bcs_pkg

// [logic/bcs_burst_counter.sv]
// Two-bit burst counter with linear or interleaved stepping.
// Assumes load and step are already qualified by the caller; load wins.
`timescale 1ns/1ns
`default_nettype none
module bcs_burst_counter import bcs_pkg::*; #(
    parameter bit INTERLEAVED = BCS_INTERLEAVED_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [BCS_BURST_W-1:0] start,
    input wire logic step,
    output logic [BCS_BURST_W-1:0] count,
    output logic [BCS_BURST_W-1:0] next_count
);
    logic [BCS_BURST_W-1:0] base; // First address of the burst
    logic [BCS_BURST_W-1:0] index; // Beats taken since the load
    logic [BCS_BURST_W-1:0] next_base;
    logic [BCS_BURST_W-1:0] next_index;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // Offset kept apart from base so both orders share one adder
    always_comb begin
        next_base = base;
        next_index = index;
        if (load) begin
            next_base = start;
            next_index = BCS_CNT_RESET;
        end else if (step) begin
            next_index = BCS_BURST_W'(index + BCS_IDX_SECOND);
        end
        if (INTERLEAVED) begin
            next_count = next_base ^ next_index;
        end else begin
            next_count = BCS_BURST_W'(next_base + next_index);
        end
    end

    // Registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            base <= BCS_CNT_RESET;
            index <= BCS_CNT_RESET;
            count <= BCS_CNT_RESET;
        end else begin
            base <= next_base;
            index <= next_index;
            count <= next_count;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_step_only;
        step && !load;
    endsequence
    sequence s_load_three_steps;
        load ##1 s_step_only ##1 s_step_only ##1 s_step_only;
    endsequence

    property p_inter_second;
        INTERLEAVED ##0 load ##1 s_step_only |=> count == ($past(count) ^ BCS_IDX_SECOND);
    endproperty
    a_inter_second: assert property (p_inter_second) else $error("second beat wrong");

    property p_inter_fourth;
        INTERLEAVED ##0 s_load_three_steps |=> count == ($past(count, 3) ^ BCS_IDX_FOURTH);
    endproperty
    a_inter_fourth: assert property (p_inter_fourth) else $error("fourth beat wrong");

    property p_linear_step;
        !INTERLEAVED ##0 s_step_only |=> count == BCS_BURST_W'($past(count) + BCS_IDX_SECOND);
    endproperty
    a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

    property p_hold;
        !load && !step |=> $stable(count);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved idle");
endmodule : bcs_burst_counter
`default_nettype wire

// [logic/bcs_sram_ctrl.sv]
// Control logic and array of a 64K by 18 synchronous burst cache SRAM.
// Assumes every pin input is synchronous to clk_sys; pads resolve the enables.
`timescale 1ns/1ns
`default_nettype none
module bcs_sram_ctrl import bcs_pkg::*; #(
    parameter int ADDR_W = BCS_ADDR_W,
    parameter bit INTERLEAVED = BCS_INTERLEAVED_DEF
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic chip_select_n,
    input wire logic write_hi_byte_n,
    input wire logic write_lo_byte_n,
    input wire logic burst_advance_n,
    input wire logic out_enable_n,
    input wire logic [BCS_DATA_W-1:0] data_in,
    input wire logic [BCS_LANES-1:0] parity_in,
    output logic [BCS_DATA_W-1:0] data_out,
    output logic [BCS_LANES-1:0] data_oe,
    output logic [BCS_LANES-1:0] parity_out,
    output logic [BCS_LANES-1:0] parity_oe
);
    localparam int DEPTH = 1 << ADDR_W; // Words in the array
    localparam int HI_W = ADDR_W - BCS_BURST_W; // Registered upper bits

    // ---------------------------------------------------------------
    // Build checks
    // ---------------------------------------------------------------
    if (ADDR_W <= BCS_BURST_W || ADDR_W > 20) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    bcs_sel_e state; // Selected or deselected
    bcs_sel_e next_state;
    logic [HI_W-1:0] addr_hi; // Upper address of the access
    logic [HI_W-1:0] next_addr_hi;
    logic [BCS_BURST_W-1:0] count; // Current burst beat
    logic [BCS_BURST_W-1:0] next_count; // Beat after this edge
    logic proc_go; // Processor strobe accepted
    logic ctrl_go; // Controller strobe seen
    logic open_go; // New access starts
    logic step_go; // Advance honoured
    logic [BCS_LANES-1:0] wr_n; // Write enables, lane order
    logic [BCS_LANES-1:0] wr_en; // Writes performed this edge
    logic [ADDR_W-1:0] wr_addr; // Location written this edge
    logic [ADDR_W-1:0] rd_addr; // Location presented next cycle
    logic [BCS_LANE_W-1:0] wdata [BCS_LANES]; // Lane data from the pins
    logic [BCS_LANE_W-1:0] rd_lane [BCS_LANES]; // Read data register
    logic [BCS_LANE_W-1:0] next_rd_lane [BCS_LANES];
    logic [BCS_LANES-1:0] lane_oe; // Registered pin drive
    logic [BCS_LANES-1:0] next_lane_oe;
    logic [BCS_LANE_W-1:0] mem [BCS_LANES][DEPTH]; // Array, one half per lane

    // ---------------------------------------------------------------
    // Strobe decode
    // ---------------------------------------------------------------
    // All decode works on the pin values at the edge; they are synchronous
    always_comb begin
        proc_go = !proc_addr_strobe_n && !chip_select_n;
        ctrl_go = !ctrl_addr_strobe_n;
        open_go = (proc_go || ctrl_go) && !chip_select_n;
        // A controller strobe or a selected processor strobe freezes the counter, even a deselecting one
        step_go = !burst_advance_n && !proc_go && !ctrl_go;
        next_state = state;
        next_addr_hi = addr_hi;
        unique case (state)
            BCS_DESEL, BCS_ACTIVE: begin
                if (open_go) begin
                    next_state = BCS_ACTIVE;
                    next_addr_hi = addr[ADDR_W-1:BCS_BURST_W];
                end else if (ctrl_go && chip_select_n) begin
                    next_state = BCS_DESEL;
                end
            end
        endcase
    end

    // Burst counter, loaded from the low address bits
    bcs_burst_counter #(
        .INTERLEAVED(INTERLEAVED)
    ) u_counter (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .load(open_go),
        .start(addr[BCS_BURST_W-1:0]),
        .step(step_go),
        .count(count),
        .next_count(next_count)
    );

    // ---------------------------------------------------------------
    // Write and read path
    // ---------------------------------------------------------------
    // A controller write lands at the address captured on the same edge
    always_comb begin
        wr_n = {write_hi_byte_n, write_lo_byte_n};
        wdata[BCS_LANE_HI] = {parity_in[BCS_LANE_HI], data_in[BCS_DATA_W-1:BCS_BYTE_W]};
        wdata[BCS_LANE_LO] = {parity_in[BCS_LANE_LO], data_in[BCS_BYTE_W-1:0]};
        wr_addr = open_go ? addr : {addr_hi, count};
        rd_addr = {next_addr_hi, next_count};
        for (int i = 0; i < BCS_LANES; i++) begin
            // Processor strobe cycle is the tag-check slot, so writes wait
            // Reset cycles never touch the array, whatever the pins show
            wr_en[i] = !wr_n[i] && (next_state == BCS_ACTIVE) && !proc_go && reset_n;
            // Bypass keeps a read of the just-written word coherent
            if (wr_en[i] && wr_addr == rd_addr) begin
                next_rd_lane[i] = wdata[i];
            end else begin
                next_rd_lane[i] = mem[i][rd_addr];
            end
            // A lane written at this edge is not driven in the next cycle; its drive in the write cycle was set an edge earlier
            next_lane_oe[i] = (next_state == BCS_ACTIVE) && !chip_select_n
                && !out_enable_n && wr_n[i];
        end
    end

    // Array: each half written on its own enable
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < BCS_LANES; i++) begin
            if (wr_en[i]) begin
                mem[i][wr_addr] <= wdata[i];
            end
        end
    end

    // ---------------------------------------------------------------
    // Control registers
    // ---------------------------------------------------------------
    // Output enable is registered too: outputs leave flops only
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= BCS_DESEL;
            addr_hi <= '0;
            lane_oe <= '0;
            for (int i = 0; i < BCS_LANES; i++) begin
                rd_lane[i] <= BCS_LANE_RESET;
            end
        end else begin
            state <= next_state;
            addr_hi <= next_addr_hi;
            lane_oe <= next_lane_oe;
            for (int i = 0; i < BCS_LANES; i++) begin
                rd_lane[i] <= next_rd_lane[i];
            end
        end
    end

    // Pins, straight from the registers
    assign data_out = {rd_lane[BCS_LANE_HI][BCS_BYTE_W-1:0], rd_lane[BCS_LANE_LO][BCS_BYTE_W-1:0]};
    assign parity_out = {rd_lane[BCS_LANE_HI][BCS_BYTE_W], rd_lane[BCS_LANE_LO][BCS_BYTE_W]};
    assign data_oe = lane_oe;
    assign parity_oe = lane_oe;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_open;
        (!proc_addr_strobe_n || !ctrl_addr_strobe_n) && !chip_select_n;
    endsequence

    property p_addr_load;
        s_open |=> addr_hi == $past(addr[ADDR_W-1:BCS_BURST_W]) && state == BCS_ACTIVE;
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("address not captured");

    property p_cnt_load;
        s_open and !burst_advance_n |=> count == $past(addr[BCS_BURST_W-1:0]);
    endproperty
    a_cnt_load: assert property (p_cnt_load) else $error("counter not loaded");

    property p_proc_no_write;
        !proc_addr_strobe_n && !chip_select_n |-> wr_en == '0;
    endproperty
    a_proc_no_write: assert property (p_proc_no_write) else $error("write in strobe slot");

    property p_proc_ignored;
        !proc_addr_strobe_n && ctrl_addr_strobe_n && chip_select_n |=> $stable(addr_hi) && $stable(state);
    endproperty
    a_proc_ignored: assert property (p_proc_ignored) else $error("strobe acted when unselected");

    property p_write_hi;
        wr_en[BCS_LANE_HI] |=> mem[BCS_LANE_HI][$past(wr_addr)] == $past(wdata[BCS_LANE_HI]);
    endproperty
    a_write_hi: assert property (p_write_hi) else $error("high lane not written");

    property p_write_lo;
        !write_lo_byte_n && ctrl_addr_strobe_n && proc_addr_strobe_n && state == BCS_ACTIVE
            |=> mem[BCS_LANE_LO][$past(wr_addr)] == $past(wdata[BCS_LANE_LO]);
    endproperty
    a_write_lo: assert property (p_write_lo) else $error("low lane not written");

    property p_lane_apart;
        wr_en == 2'h2 |=> mem[BCS_LANE_LO][$past(wr_addr)] == $past(mem[BCS_LANE_LO][wr_addr]);
    endproperty
    a_lane_apart: assert property (p_lane_apart) else $error("low lane disturbed");

    property p_deselect;
        !ctrl_addr_strobe_n && chip_select_n |=> state == BCS_DESEL && lane_oe == '0;
    endproperty
    a_deselect: assert property (p_deselect) else $error("not deselected");

    property p_drive_cause;
        lane_oe != '0 |-> $past(!out_enable_n && !chip_select_n);
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("drive without enable");

    property p_write_release;
        !write_hi_byte_n |=> !data_oe[BCS_LANE_HI] && !parity_oe[BCS_LANE_HI];
    endproperty
    a_write_release: assert property (p_write_release) else $error("written lane driven");

    property p_both_strobes;
        !proc_addr_strobe_n && !ctrl_addr_strobe_n && !chip_select_n && !write_lo_byte_n |-> !wr_en[BCS_LANE_LO];
    endproperty
    a_both_strobes: assert property (p_both_strobes) else $error("controller strobe acted");
endmodule : bcs_sram_ctrl
`default_nettype wire

// [verification/bcs_host_pins.sv]
// Far-side pin model: host data drivers meeting the device on shared wires.
// Assumes one clock; the host drives a lane only in a cycle where it writes it.
`timescale 1ns/1ns
`default_nettype none
module bcs_host_pins import bcs_pkg::*; (
    input wire logic clk_sys,
    input wire logic [BCS_DATA_W-1:0] dev_data,
    input wire logic [BCS_LANES-1:0] dev_parity,
    input wire logic [BCS_LANES-1:0] dev_oe,
    input wire logic [BCS_DATA_W-1:0] host_data,
    input wire logic [BCS_LANES-1:0] host_parity,
    input wire logic [BCS_LANES-1:0] host_drive,
    output logic [BCS_DATA_W-1:0] data_in,
    output logic [BCS_LANES-1:0] parity_in
);
    // ---------------------------------------------------------------
    // Wire resolution
    // ---------------------------------------------------------------
    logic [BCS_DATA_W-1:0] last_data = '0; // Level at the last edge
    logic [BCS_LANES-1:0] last_parity = '0;
    // Host wins; a released lane shows the inverse of its last level,
    // so a stale value can never pass for fresh data
    always_comb begin
        for (int i = 0; i < BCS_LANES; i++) begin
            if (host_drive[i]) begin
                data_in[i*BCS_BYTE_W +: BCS_BYTE_W] = host_data[i*BCS_BYTE_W +: BCS_BYTE_W];
                parity_in[i] = host_parity[i];
            end else if (dev_oe[i]) begin
                data_in[i*BCS_BYTE_W +: BCS_BYTE_W] = dev_data[i*BCS_BYTE_W +: BCS_BYTE_W];
                parity_in[i] = dev_parity[i];
            end else begin
                data_in[i*BCS_BYTE_W +: BCS_BYTE_W] = ~last_data[i*BCS_BYTE_W +: BCS_BYTE_W];
                parity_in[i] = ~last_parity[i];
            end
        end
    end
    // Remember the wire for the floating pattern
    always @(posedge clk_sys) begin
        last_data <= data_in;
        last_parity <= parity_in;
    end
endmodule : bcs_host_pins
`default_nettype wire

// [verification/test_burst_cache_sram_control.sv]
// Self-checking bench for the burst SRAM control, both counter variants side by side.
// Assumes bcs_pkg, bcs_sram_ctrl and bcs_host_pins are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        failures++; \
        $display("wrong value t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module test_burst_cache_sram_control import bcs_pkg::*; ;
    // ---------------------------------------------------------------
    // Pins and reference state
    // ---------------------------------------------------------------
    logic clk_sys, reset_n, proc_n, ctrl_n, cs_n, adv_n, oe_n; // Pin drive
    logic [1:0] we_n, host_drive, host_par; // Lane 1 is the high byte
    logic [15:0] addr, host_data;
    logic [15:0] dout [2], din [2]; // Index 0 linear, 1 interleaved
    logic [1:0] pout [2], par_in [2], doe [2], poe [2];
    logic act, zero; // Model selection, outputs-cleared flag
    logic [13:0] ahi; // Registered upper address
    logic [1:0] base, idx, exp_oe; // Burst start and beat offset
    logic [17:0] mem [int], exp_lane [2]; // Array model keyed by variant
    logic [1:0] mask [int], exp_known [2]; // Lanes ever written
    logic [15:0] lfsr = 16'hFC7F;
    int failures = 0;
    int samples_checked = 0;
    // ---------------------------------------------------------------
    // Devices under test, one per counter variant
    // ---------------------------------------------------------------
    for (genvar v = 0; v < 2; v++) begin : g_var
        bcs_host_pins host (.clk_sys(clk_sys), .dev_data(dout[v]), .dev_parity(pout[v]), .dev_oe(doe[v]),
            .host_data(host_data), .host_parity(host_par), .host_drive(host_drive),
            .data_in(din[v]), .parity_in(par_in[v]));
        bcs_sram_ctrl #(.ADDR_W(BCS_ADDR_W), .INTERLEAVED(v == 1)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
            .addr(addr), .proc_addr_strobe_n(proc_n), .ctrl_addr_strobe_n(ctrl_n), .chip_select_n(cs_n),
            .write_hi_byte_n(we_n[1]), .write_lo_byte_n(we_n[0]), .burst_advance_n(adv_n),
            .out_enable_n(oe_n), .data_in(din[v]), .parity_in(par_in[v]), .data_out(dout[v]),
            .data_oe(doe[v]), .parity_out(pout[v]), .parity_oe(poe[v]));
    end
    // ---------------------------------------------------------------
    // Expectation functions and tasks
    // ---------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next
    // Current beat for a variant
    function automatic logic [1:0] beat(input int v);
        return (v == 1) ? (base ^ idx) : 2'(base + idx);
    endfunction : beat
    // Reference step at a rising edge, from the sampled pins
    task automatic model_edge();
        int key;
        int wkey [2]; // Written location: beat before any advance, or the new address
        logic [17:0] wd;
        wd = {host_par[1], host_data[15:8], host_par[0], host_data[7:0]};
        zero = !reset_n;
        for (int v = 0; v < 2; v++) begin
            wkey[v] = (v << 16) | int'({ahi, beat(v)});
        end
        if (!reset_n) begin
            act = 1'b0; ahi = '0; base = '0; idx = '0;
        end else if (!cs_n && (!proc_n || !ctrl_n)) begin
            act = 1'b1; ahi = addr[15:2]; base = addr[1:0]; idx = '0;
            wkey[0] = int'(addr);
            wkey[1] = (1 << 16) | int'(addr);
        end else if (!ctrl_n && cs_n) begin
            act = 1'b0;
        end else if (!adv_n && ctrl_n) begin
            idx = idx + 2'h1;
        end
        for (int v = 0; v < 2; v++) begin
            key = (v << 16) | int'({ahi, beat(v)});
            if (!mem.exists(key)) begin
                mem[key] = '0; mask[key] = '0;
            end
            if (!mem.exists(wkey[v])) begin
                mem[wkey[v]] = '0;
                mask[wkey[v]] = '0;
            end
            for (int i = 0; i < 2; i++) begin
                // Write slot is lost with processor strobe and chip select
                if (reset_n && act && !we_n[i] && !(!proc_n && !cs_n)) begin
                    mem[wkey[v]][i*9 +: 9] = wd[i*9 +: 9];
                    mask[wkey[v]][i] = 1'b1;
                end
                exp_oe[i] = reset_n && !oe_n && !cs_n && act && we_n[i];
            end
            exp_lane[v] = mem[key];
            exp_known[v] = mask[key];
        end
    endtask : model_edge
    // Compare both variants; only lanes known and driven carry data
    task automatic check_outputs();
        for (int v = 0; v < 2; v++) begin
            `CHK(doe[v], exp_oe)
            `CHK(poe[v], exp_oe)
            for (int i = 0; i < 2; i++) begin
                if (zero) `CHK({pout[v][i], dout[v][i*8 +: 8]}, 9'h000)
                else if (exp_oe[i] && exp_known[v][i]) `CHK({pout[v][i], dout[v][i*8 +: 8]}, exp_lane[v][i*9 +: 9])
            end
        end
    endtask : check_outputs
    // One cycle: drive at falling edge, model at rising, check at next fall.
    // ctl = {proc, ctrl, cs, wh, wl, adv, oe}, all active low
    task automatic cyc(input logic [6:0] ctl, input logic [15:0] a, input logic [17:0] d);
        {proc_n, ctrl_n, cs_n, we_n, adv_n, oe_n} = ctl;
        addr = a;
        {host_par[1], host_data[15:8], host_par[0], host_data[7:0]} = d;
        host_drive = ~ctl[3:2]; // Host drives exactly the lanes it writes
        @(posedge clk_sys);
        model_edge();
        @(negedge clk_sys);
        check_outputs();
    endtask : cyc
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    // ---------------------------------------------------------------
    // Clock, watchdog, sequence
    // ---------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #(BCS_CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
    end
    // Run needs about 3040 cycles
    initial begin
        #(4000 * BCS_CLK_PERIOD_NS);
        failures++;
        complete_run();
    end
    initial begin
        reset_n = 1'b0;
        repeat (6) cyc(7'h7F, 16'h0000, 18'h00000);
        reset_n = 1'b1;
        // Fill one burst block by controller writes
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            cyc(7'h43, 16'h0100 + 16'(i), {lfsr[1:0], lfsr});
        end
        // Every start value, four advances to see the wrap
        for (int s = 0; s < 4; s++) begin
            cyc(7'h2E, 16'h0100 + 16'(s), 18'h00000);
            repeat (4) cyc(7'h6C, 16'h0000, 18'h00000);
        end
        cyc(7'h03, 16'h0102, 18'h3FFFF); // Both strobes: write slot lost
        cyc(7'h2E, 16'h0102, 18'h00000);
        cyc(7'h2F, 16'h0103, 18'h00000); // Processor write, tag slot
        cyc(7'h67, 16'h0000, 18'h2A5A5); // High lane only
        cyc(7'h2E, 16'h0103, 18'h00000);
        cyc(7'h3C, 16'h0000, 18'h00000); // Unselected processor strobe
        cyc(7'h5E, 16'h0000, 18'h00000); // Deselect
        cyc(7'h6B, 16'h0000, 18'h15A5A); // Dropped while deselected
        cyc(7'h4E, 16'h0101, 18'h00000);
        // Random traffic, short reset in the middle
        for (int n = 0; n < 3000; n++) begin
            logic [15:0] r;
            logic [15:0] a;
            lfsr = lfsr_next(lfsr);
            r = lfsr;
            lfsr = lfsr_next(lfsr);
            a = {lfsr[0] ? 14'h3FFF : {11'h000, lfsr[3:1]}, lfsr[5:4]};
            reset_n = (n < 1500 || n > 1501);
            cyc({|r[1:0], |r[3:2], &r[5:4], |r[7:6], |r[9:8], r[10], &r[12:11]}, a, {lfsr[15:14], r});
        end
        complete_run();
    end
endmodule : test_burst_cache_sram_control
`undef CHK
`default_nettype wire
